//--- rtl/mmbs_consts.vh
// Constants for the memory map, boot select and code security block.
// Assumes a 16-bit word-addressed program and data space.
`ifndef MMBS_CONSTS_VH
`define MMBS_CONSTS_VH

// Program space windows
`define MMBS_BOOT_BASE 16'h0000
`define MMBS_BOOT_LAST 16'h00ff
`define MMBS_FLASH_LAST 16'h7fff
`define MMBS_SEC1_BASE 16'h1000
`define MMBS_SEC2_BASE 16'h4000
`define MMBS_SEC3_BASE 16'h7000
`define MMBS_PRAM_BASE 16'h8000
`define MMBS_PRAM_LAST 16'h87ff

// Data space window of the single access RAM
`define MMBS_DRAM_BASE 16'h8000
`define MMBS_DRAM_LAST 16'h87ff

// Stored password and password entry words
`define MMBS_PWD_BASE 16'h0040
`define MMBS_KEY_BASE 16'h77f0
`define MMBS_KEY_HI_MASK 16'hfffc

// System control status 2 layout and reset values
`define MMBS_SCS2_PON_BIT 0
`define MMBS_SCS2_DON_BIT 1
`define MMBS_SCS2_BOOT_BIT 3
`define MMBS_RAM_ON_RST 1'b1
`define MMBS_BOOT_DIS_RST 1'b1

// Clock multipliers picked by the strap
`define MMBS_MULT_LOW 3'h2
`define MMBS_MULT_HIGH 3'h4

// Cycles after reset release before straps are caught
`define MMBS_STRAP_WAIT 3'h4

`endif

//--- rtl/mmbs_sync3.v
// Three stage input synchroniser with agreement filter.
// Assumes one clock; the input may change at any time.
module mmbs_sync3 (
	// Clock and reset
	input wire i_clk,
	input wire i_rst_n,
	// Raw input and a reset level port that the stages ignore; they always reset high
	input wire i_async,
	input wire i_rst_val,
	// Qualified level
	output reg o_level
);

	reg s1_q; // First stage, read only by the second
	reg s2_q; // Second stage
	reg s3_q; // Third stage

	// Shift chain; output follows once the last two stages agree
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
			o_level <= 1'b1;
		end else begin
			s1_q <= i_async;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				o_level <= s3_q;
			end
		end
	end

	// Reset level port kept for callers wanting a pulled-up default
	wire unused_rst_val;
	assign unused_rst_val = i_rst_val;

endmodule // mmbs_sync3

//--- rtl/mmbs_top.v
// Memory map decode, boot ROM select and code security unlock.
// Assumes a zero wait CPU access port and flash read data in the same
// cycle as the access; external host accesses are flagged by i_acc_host.
//
// What this block does
// RULE_01 - Two bits map RAM; reset to both
// RULE_02 - RAM off sends 8000h program to external
// RULE_03 - Four flash sectors, each write protectable
// RULE_04 - Flash fetches complete with zero wait states
// RULE_05 - Boot ROM at 0000-00FF, pin low enables
// RULE_06 - Pin low at reset clears bit 3
// RULE_07 - Write 0 enables, 1 disables boot ROM
// RULE_08 - Flash disabled while boot ROM enabled
// RULE_09 - Transmit strap low gives x2, else x4
// RULE_10 - Secured state blocks host program reads
// RULE_11 - Host dummy reads words 40h-43h first
// RULE_12 - Host writes matching password to 77F0h-77F3h
// RULE_13 - Blank password unlocks after dummy read
// RULE_14 - Unsecured one cycle after final step
// RULE_15 - Reset returns to secured state
// RULE_16 - Mismatch keeps device secured until redone
`include "mmbs_consts.vh"
module mmbs_top (
	// Clock and reset
	input wire i_clk,
	input wire i_arst_n,
	// Strap pins
	input wire i_boot_select_n,
	input wire i_serial_transmit_strap,
	// System control status 2 write port
	input wire i_scs2_we,
	input wire [15:0] i_scs2_wdata,
	// Flash sector write protect, one bit per sector
	input wire [3:0] i_sector_protect,
	// Memory access port
	input wire i_acc_valid,
	input wire i_acc_prog,
	input wire i_acc_wr,
	input wire i_acc_host,
	input wire [15:0] i_acc_addr,
	input wire [15:0] i_acc_wdata,
	input wire [15:0] i_acc_rdata,
	// Decode results
	output reg o_sel_boot,
	output reg o_sel_flash,
	output reg o_sel_ram,
	output reg o_sel_ext,
	output reg [1:0] o_flash_sector,
	output reg o_flash_wr_ok,
	output wire o_acc_ready,
	output wire o_acc_deny,
	// State
	output wire [15:0] o_scs2,
	output reg [2:0] o_pll_mult,
	output reg o_strap_done,
	output reg o_unsecured
);

	// Reset release through two flops
	reg rst_s1_q;
	reg rst_n;
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_s1_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n <= rst_s1_q;
		end
	end

	// Qualified strap levels
	wire boot_pin;
	wire txd_pin;
	mmbs_sync3 u_sync_boot (
		.i_clk(i_clk),
		.i_rst_n(rst_n),
		.i_async(i_boot_select_n),
		.i_rst_val(1'b1),
		.o_level(boot_pin)
	);
	mmbs_sync3 u_sync_txd (
		.i_clk(i_clk),
		.i_rst_n(rst_n),
		.i_async(i_serial_transmit_strap),
		.i_rst_val(1'b1),
		.o_level(txd_pin)
	);

	// Control bits of system control status 2
	reg program_space_ram_on_q; // RAM seen in program space
	reg data_space_ram_on_q; // RAM seen in data space
	reg boot_dis_q; // 1 = boot ROM off, flash on
	reg [2:0] strap_cnt_q; // Settle count after release
	wire strap_catch;
	assign strap_catch = !o_strap_done && (strap_cnt_q == `MMBS_STRAP_WAIT);

	// Control bits and strap capture
	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			program_space_ram_on_q <= `MMBS_RAM_ON_RST; // [RULE_01]
			data_space_ram_on_q <= `MMBS_RAM_ON_RST; // [RULE_01]
			boot_dis_q <= `MMBS_BOOT_DIS_RST;
			strap_cnt_q <= 3'h0;
			o_strap_done <= 1'b0;
			o_pll_mult <= `MMBS_MULT_HIGH;
		end else begin
			if (!o_strap_done) begin
				strap_cnt_q <= strap_cnt_q + 3'h1;
			end
			if (strap_catch) begin
				// Low pin at reset clears the disable bit
				o_strap_done <= 1'b1;
				boot_dis_q <= boot_pin; // [RULE_05] [RULE_06]
				// Pulled-up pin reads high and gives the default
				o_pll_mult <= txd_pin ? `MMBS_MULT_HIGH :
					`MMBS_MULT_LOW; // [RULE_09]
			end else if (i_scs2_we) begin
				// Software writes map bits and boot disable
				program_space_ram_on_q <=
					i_scs2_wdata[`MMBS_SCS2_PON_BIT]; // [RULE_01]
				data_space_ram_on_q <=
					i_scs2_wdata[`MMBS_SCS2_DON_BIT]; // [RULE_01]
				boot_dis_q <= i_scs2_wdata[`MMBS_SCS2_BOOT_BIT]; // [RULE_07]
			end
		end
	end

	// Readback of the control word; unused bits read zero
	assign o_scs2 = {12'h000, boot_dis_q, 1'b0, data_space_ram_on_q,
		program_space_ram_on_q};

	// Address decode of the access port
	always @* begin
		o_sel_boot = 1'b0;
		o_sel_flash = 1'b0;
		o_sel_ram = 1'b0;
		o_sel_ext = 1'b0;
		o_flash_sector = 2'h0;
		o_flash_wr_ok = 1'b0;
		// Sector index from the 4K/12K/12K/4K split
		if (i_acc_addr >= `MMBS_SEC3_BASE) begin
			o_flash_sector = 2'h3; // [RULE_03]
		end else if (i_acc_addr >= `MMBS_SEC2_BASE) begin
			o_flash_sector = 2'h2; // [RULE_03]
		end else if (i_acc_addr >= `MMBS_SEC1_BASE) begin
			o_flash_sector = 2'h1; // [RULE_03]
		end
		if (i_acc_valid && i_acc_prog) begin
			if (!boot_dis_q && i_acc_addr <= `MMBS_BOOT_LAST) begin
				o_sel_boot = 1'b1; // [RULE_05]
			end else if (i_acc_addr <= `MMBS_FLASH_LAST) begin
				// Flash stays dark while the boot ROM is on
				o_sel_flash = boot_dis_q; // [RULE_08]
				// Writes allowed only into unprotected sectors
				o_flash_wr_ok = boot_dis_q && i_acc_wr &&
					!i_sector_protect[o_flash_sector]; // [RULE_03]
			end else if (i_acc_addr <= `MMBS_PRAM_LAST) begin
				// RAM window, forwarded outside when unmapped
				o_sel_ram = program_space_ram_on_q; // [RULE_01]
				o_sel_ext = !program_space_ram_on_q; // [RULE_02]
			end else begin
				o_sel_ext = 1'b1;
			end
		end else if (i_acc_valid) begin
			if (data_space_ram_on_q && i_acc_addr >= `MMBS_DRAM_BASE &&
				i_acc_addr <= `MMBS_DRAM_LAST) begin
				o_sel_ram = 1'b1; // [RULE_01]
			end
		end
	end

	// Every access, flash included, completes in its own cycle
	assign o_acc_ready = 1'b1; // [RULE_04]

	// Host reads of program memory are refused while secured
	assign o_acc_deny = i_acc_valid && i_acc_host && i_acc_prog &&
		!i_acc_wr && !o_unsecured; // [RULE_10]

	// Security unlock state
	reg [15:0] pwd_q [0:3]; // Stored words seen by the dummy read
	reg [3:0] read_seen_q; // Which stored words were read
	reg [3:0] key_ok_q; // Which entry words matched
	wire [1:0] word_idx;
	wire pwd_rd;
	wire key_wr;
	wire blank;
	wire key_hit;
	wire [3:0] key_ok_next;
	wire unlock_now;
	wire [3:0] seen_next; // Words seen once this cycle's read lands
	wire [15:0] pwd_n0; // Stored word 0 once this cycle's read lands
	wire [15:0] pwd_n1; // Stored word 1 once this cycle's read lands
	wire [15:0] pwd_n2; // Stored word 2 once this cycle's read lands
	wire [15:0] pwd_n3; // Stored word 3 once this cycle's read lands
	integer k;

	assign word_idx = i_acc_addr[1:0];
	// Dummy read of the stored words in program space
	assign pwd_rd = i_acc_valid && i_acc_prog && !i_acc_wr &&
		((i_acc_addr & `MMBS_KEY_HI_MASK) == `MMBS_PWD_BASE); // [RULE_11]
	// Entry writes to the password window in data space
	assign key_wr = i_acc_valid && !i_acc_prog && i_acc_wr &&
		(read_seen_q == 4'hf) &&
		((i_acc_addr & `MMBS_KEY_HI_MASK) == `MMBS_KEY_BASE); // [RULE_12]
	assign key_hit = key_wr && (i_acc_wdata == pwd_q[word_idx]);
	// Look ahead past the current dummy read so that the final read
	// unlocks at its own edge, the same latency as the final write
	assign seen_next = pwd_rd ? (read_seen_q | (4'h1 << word_idx)) :
		read_seen_q;
	assign pwd_n0 = (pwd_rd && word_idx == 2'h0) ? i_acc_rdata : pwd_q[0];
	assign pwd_n1 = (pwd_rd && word_idx == 2'h1) ? i_acc_rdata : pwd_q[1];
	assign pwd_n2 = (pwd_rd && word_idx == 2'h2) ? i_acc_rdata : pwd_q[2];
	assign pwd_n3 = (pwd_rd && word_idx == 2'h3) ? i_acc_rdata : pwd_q[3];
	// Blank stored password needs no entry
	assign blank = ((pwd_n0 & pwd_n1 & pwd_n2 & pwd_n3) == 16'hffff) ||
		((pwd_n0 | pwd_n1 | pwd_n2 | pwd_n3) == 16'h0000); // [RULE_13]
	assign key_ok_next = key_hit ? (key_ok_q | (4'h1 << word_idx)) :
		key_ok_q;
	// A read restarts entry, so only a blank store unlocks on a read
	assign unlock_now = (seen_next == 4'hf) &&
		(blank || (!pwd_rd && key_ok_next == 4'hf));

	// Dummy read capture, password match and unlock
	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (k = 0; k < 4; k = k + 1) begin
				pwd_q[k] <= 16'h0000;
			end
			read_seen_q <= 4'h0;
			key_ok_q <= 4'h0;
			o_unsecured <= 1'b0; // [RULE_15]
		end else begin
			if (pwd_rd) begin
				// A fresh dummy read restarts the entry sequence
				pwd_q[word_idx] <= i_acc_rdata; // [RULE_11]
				read_seen_q <= read_seen_q | (4'h1 << word_idx);
				key_ok_q <= 4'h0;
			end else if (key_wr && !key_hit) begin
				// Wrong word throws away partial matches
				key_ok_q <= 4'h0; // [RULE_16]
			end else begin
				key_ok_q <= key_ok_next; // [RULE_12]
			end
			// Unsecured from the edge after the final step
			if (!(key_wr && !key_hit) && unlock_now) begin
				o_unsecured <= 1'b1; // [RULE_14] [RULE_13]
			end
		end
	end

endmodule // mmbs_top

//--- dv/mmbs_top_props.sv
// Checker for the memory map, boot select and security block.
// Bound to mmbs_top; it sees that module's ports only.
module mmbs_top_props (
	input wire i_clk, i_arst_n, i_boot_select_n,
	input wire i_serial_transmit_strap, i_scs2_we,
	input wire [15:0] i_scs2_wdata, i_acc_addr,
	input wire [3:0] i_sector_protect,
	input wire i_acc_valid, i_acc_prog, i_acc_wr, i_acc_host,
	input wire o_sel_boot, o_sel_flash, o_sel_ram, o_sel_ext,
	input wire [1:0] o_flash_sector,
	input wire o_flash_wr_ok, o_acc_ready, o_acc_deny,
	input wire [15:0] o_scs2,
	input wire [2:0] o_pll_mult,
	input wire o_strap_done, o_unsecured
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	// Program space access this cycle
	wire pa = i_acc_valid && i_acc_prog;
	// Expected flash sector of the address
	wire [1:0] sec = (i_acc_addr < 16'h1000) ? 2'h0 :
		(i_acc_addr < 16'h4000) ? 2'h1 :
		(i_acc_addr < 16'h7000) ? 2'h2 : 2'h3;
	// Straps caught
	sequence s_catch;
		$rose(o_strap_done);
	endsequence
	// Control word written once straps are in
	sequence s_ctl_wr;
		i_scs2_we && o_strap_done;
	endsequence
	zero_wait_a: assert property (o_acc_ready)
		else $error("access not ready at once");
	strap_mult_a: assert property (s_catch |-> o_pll_mult ==
		(i_serial_transmit_strap ? 3'h4 : 3'h2)) else $error("bad mult");
	strap_boot_a: assert property (s_catch |-> o_scs2[3] ==
		i_boot_select_n) else $error("boot bit not from pin");
	ctl_write_a: assert property (s_ctl_wr |=>
		o_scs2[3:0] == ($past(i_scs2_wdata[3:0]) & 4'hb))
		else $error("control word not taken");
	boot_map_a: assert property (pa && i_acc_addr <= 16'h00ff &&
		!o_scs2[3] |-> o_sel_boot) else $error("boot ROM not selected");
	flash_gate_a: assert property (pa && i_acc_addr <= 16'h7fff |->
		o_sel_flash == o_scs2[3]) else $error("flash gating wrong");
	ram_fwd_a: assert property (pa && i_acc_addr[15:11] == 5'h10 |->
		o_sel_ram == o_scs2[0] && o_sel_ext == !o_scs2[0])
		else $error("program RAM window wrong");
	sector_map_a: assert property (pa && o_sel_flash |->
		o_flash_sector == sec && (!i_acc_wr ||
		o_flash_wr_ok == !i_sector_protect[sec]))
		else $error("sector decode wrong");
	host_deny_a: assert property (pa && !i_acc_wr && i_acc_host |->
		o_acc_deny == !o_unsecured) else $error("deny wrong");
	unlock_cause_a: assert property ($rose(o_unsecured) |->
		$past(i_acc_valid && (i_acc_prog ^ i_acc_wr)))
		else $error("unlock without access");
	unlock_hold_a: assert property (o_unsecured |=> o_unsecured)
		else $error("unlock lost");
endmodule // mmbs_top_props

bind mmbs_top mmbs_top_props u_props (.*);

//--- dv/mmbs_host_model.sv
// Stored password words seen at program words 40h-43h.
// Assumes reads answer in the same cycle, as the block expects.
module mmbs_host_model #(
	parameter [63:0] KEY = 64'h1357_9bdf_2468_ace0 // Arbitrary value
) (
	input wire logic i_prog,
	input wire logic i_blank,
	input wire logic [15:0] i_addr,
	output logic [15:0] o_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// Blank store on request; elsewhere a pattern that moves
	always_comb begin
		if (i_blank)
			o_rdata = 16'hffff;
		else if (i_prog && i_addr[15:2] == 14'h0010)
			o_rdata = KEY[i_addr[1:0]*16 +: 16];
		else
			o_rdata = ~i_addr;
	end
endmodule // mmbs_host_model

//--- dv/testbench.sv
// Self-checking bench for the memory map and security block.
// Drives the access port at rising edges; the model gives read data.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam [63:0] KEY = 64'h1357_9bdf_2468_ace0;
	logic clk = 1'b0, arst_n = 1'b0, boot_n = 1'b0, strap = 1'b0;
	logic we = 1'b0, valid = 1'b0, prog = 1'b0, wr = 1'b0, host = 1'b0;
	logic blank = 1'b0, sb, sf, sr, se, wok, rdy, deny, done, unsec;
	logic [15:0] wdata = 16'h0, addr = 16'h0, adata = 16'h0, rdata, scs2;
	logic [15:0] cn [4] = '{16'h0fff, 16'h1000, 16'h6fff, 16'h7000};
	logic [3:0] prot = 4'h0;
	logic [1:0] sec;
	logic [2:0] mult;
	logic [31:0] seed = 32'hb4e6;
	int num_errors = 0, checked = 0;
	always #5 clk = ~clk;
	mmbs_host_model u_host (.i_prog(prog), .i_blank(blank), .i_addr(addr),
		.o_rdata(rdata));
	mmbs_top u_dut (.i_clk(clk), .i_arst_n(arst_n), .i_boot_select_n(boot_n),
		.i_serial_transmit_strap(strap), .i_scs2_we(we),
		.i_scs2_wdata(wdata), .i_sector_protect(prot),
		.i_acc_valid(valid), .i_acc_prog(prog), .i_acc_wr(wr),
		.i_acc_host(host), .i_acc_addr(addr), .i_acc_wdata(adata),
		.i_acc_rdata(rdata), .o_sel_boot(sb), .o_sel_flash(sf),
		.o_sel_ram(sr), .o_sel_ext(se), .o_flash_sector(sec),
		.o_flash_wr_ok(wok), .o_acc_ready(rdy), .o_acc_deny(deny),
		.o_scs2(scs2), .o_pll_mult(mult), .o_strap_done(done),
		.o_unsecured(unsec));
	// Next random word
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// Expected sector of a flash address
	function automatic logic [1:0] sec_of(input logic [15:0] a);
		return a < 16'h1000 ? 2'h0 : a < 16'h4000 ? 2'h1 :
			a < 16'h7000 ? 2'h2 : 2'h3;
	endfunction
	task automatic complete_run();
		if (num_errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One access cycle; protect bits move at random with it
	task automatic acc(input logic p, w, h, input logic [15:0] a, d);
		@(posedge clk);
		seed = xs(seed);
		{valid, prog, wr, host, addr, adata} <= {1'b1, p, w, h, a, d};
		{we, prot} <= {1'b0, seed[3:0]};
		#1;
	endtask
	task automatic idle();
		@(posedge clk);
		valid <= 1'b0;
		#1;
	endtask
	// Reset with given straps, then wait for the catch
	task automatic rst(input logic b, s, k);
		@(posedge clk);
		{arst_n, valid, boot_n, strap, blank} <= {2'b00, b, s, k};
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		for (int i = 0; i < 20 && done !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		if (done !== 1'b1) begin
			num_errors++;
			complete_run();
		end
	endtask
	initial begin
		#100000;
		num_errors++;
		complete_run();
	end
	initial begin
		rst(1'b0, 1'b0, 1'b0);
		chk(scs2, 16'h0003);
		chk(mult, 16'h2);
		acc(1, 0, 0, 16'h00ff, 0);
		chk({sb, sf}, 16'h2);
		@(posedge clk);
		{we, wdata} <= {1'b1, 16'h000a};
		acc(1, 0, 0, 16'h8004, 0);
		chk({se, sr}, 16'h2);
		chk(scs2, 16'h000a);
		for (int i = 0; i < 16; i++) begin
			acc(1, 1, 0, i < 4 ? cn[i] : {1'b0, seed[30:16]}, 0);
			chk({sf, sec, wok}, {1'b1, sec_of(addr), !prot[sec_of(addr)]});
		end
		acc(1, 0, 1, 16'h0040, 0);
		chk(deny, 16'h1);
		for (int i = 0; i < 4; i++) acc(1, 0, 0, {14'h0010, i[1:0]}, 0);
		for (int i = 0; i < 4; i++) acc(0, 1, 1, {14'h1dfc, i[1:0]},
			KEY[i*16 +: 16] ^ {15'h0, i == 3});
		idle();
		chk(unsec, 16'h0);
		for (int i = 0; i < 4; i++) acc(0, 1, 1, {14'h1dfc, i[1:0]},
			KEY[i*16 +: 16]);
		chk(unsec, 16'h0);
		idle();
		chk(unsec, 16'h1);
		rst(1'b1, 1'b1, 1'b1);
		chk({unsec, mult, scs2[3:0]}, 16'h4b);
		acc(0, 0, 0, 16'h87ff, 0);
		chk(sr, 16'h1);
		for (int i = 3; i >= 0; i--) acc(1, 0, 1, {14'h0010, i[1:0]}, 0);
		idle();
		chk(unsec, 16'h1);
		complete_run();
	end
endmodule // testbench
